// >>> src/hbridge_fault_consts.vh
// constants for the h-bridge fault and mode controller
`ifndef HBRIDGE_FAULT_CONSTS_VH
`define HBRIDGE_FAULT_CONSTS_VH
`define CLK_PERIOD_NS 50
`define OC_DEGLITCH_NS 1000
`define OC_DEGLITCH_CYC ((`OC_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_RETRY_US 1000
`define OC_RETRY_CYC ((`OC_RETRY_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_US 250
`define WAKE_CYC ((`WAKE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_US 1
`define SLEEP_CYC ((`SLEEP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16
`define DRV_COAST 2'h0
`define DRV_REVERSE 2'h1
`define DRV_FORWARD 2'h2
`define DRV_BRAKE 2'h3
`endif

// >>> src/bridge_oc_guard.v
// per-bridge overcurrent deglitch, shutdown and auto-retry
`timescale 1ns/1ns
`include "hbridge_fault_consts.vh"
module bridge_oc_guard #(
    parameter [15:0] DEGLITCH_CYC = `OC_DEGLITCH_CYC,
    parameter [15:0] RETRY_CYC = `OC_RETRY_CYC
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire clear_in,
    input wire [3:0] fet_limit_in,
    input wire sense_over_in,
    output reg shut_out
);
    reg [15:0] cnt_reg;
    // any fet or the sense pin counts as overcurrent
    wire oc_now = (|fet_limit_in) | sense_over_in;
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_reg <= 16'h0000;
            shut_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (clear_in)
            begin
                cnt_reg <= 16'h0000;
                shut_out <= 1'b0;
            end
            else if (shut_out)
            begin
                // re-enable after retry; loop repeats if still over
                if (cnt_reg >= RETRY_CYC - 16'h0001)
                begin
                    shut_out <= 1'b0;
                    cnt_reg <= 16'h0000;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            else if (oc_now)
            begin
                if (cnt_reg >= DEGLITCH_CYC - 16'h0001)
                begin
                    shut_out <= 1'b1;
                    cnt_reg <= 16'h0000;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            else
                cnt_reg <= 16'h0000;
        end
    end
endmodule // bridge_oc_guard

// >>> src/hbridge_fault_mode_control.v
// fault protection and mode sequencing for a dual h-bridge driver
// Contract
// - current limit longer than deglitch time shuts bridge, fault low
// - after retry period the bridge re-enables and fault releases
// - persisting overcurrent repeats deglitch, shutdown, retry forever
// - overcurrent shutdown affects only the offending bridge
// - each high-side and low-side fet is watched separately
// - sense pin over its own threshold also counts as overcurrent
// - overtemperature disables all fets and pulls fault low
// - thermal shutdown recovers by itself once cooled below hysteresis
// - supply below falling threshold disables all and resets logic
// - lockout ends only above the separate rising threshold
// - fault held low during lockout, released when operation restarts
// - active only with supply good, sleep input high, wake elapsed
// - sleep input low disables bridge and logic after entry time
// - power-up with sleep input low goes straight to sleep
// - any fault disables bridge; logic keeps running except lockout
// - leave fault mode as soon as its recovery condition holds
// - inputs decode 00 coast, 01 reverse, 10 forward, 11 brake
`timescale 1ns/1ns
`include "hbridge_fault_consts.vh"
module hbridge_fault_mode_control #(
    parameter [15:0] OC_DEGLITCH_CYC = `OC_DEGLITCH_CYC,
    parameter [15:0] OC_RETRY_CYC = `OC_RETRY_CYC,
    parameter [15:0] WAKE_CYC = `WAKE_CYC,
    parameter [15:0] SLEEP_CYC = `SLEEP_CYC
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire sleep_in_low_in,
    input wire bridge_a_input_1_in,
    input wire bridge_a_input_2_in,
    input wire bridge_b_input_1_in,
    input wire bridge_b_input_2_in,
    input wire [3:0] a_fet_limit_in,
    input wire [3:0] b_fet_limit_in,
    input wire a_sense_over_in,
    input wire b_sense_over_in,
    input wire over_temp_in,
    input wire temp_cooled_in,
    input wire supply_below_fall_in,
    input wire supply_above_rise_in,
    output reg [1:0] a_high_on_out,
    output reg [1:0] a_low_on_out,
    output reg [1:0] b_high_on_out,
    output reg [1:0] b_low_on_out,
    output reg fault_out_low_out,
    output reg fault_out_low_oe_out,
    output reg active_out,
    output reg regulator_on_out
);
    // =====================================================
    // mode state machine
    localparam [3:0] ST_LOCKOUT = 4'h1;
    localparam [3:0] ST_SLEEP = 4'h2;
    localparam [3:0] ST_WAKE = 4'h4;
    localparam [3:0] ST_ACTIVE = 4'h8;

    function [3:0] fet_map;
        input [1:0] code;
        begin
            // order: high1, high2, low1, low2
            case (code)
                `DRV_REVERSE: fet_map = 4'h6;
                `DRV_FORWARD: fet_map = 4'h9;
                `DRV_BRAKE: fet_map = 4'h3;
                default: fet_map = 4'h0;
            endcase
        end
    endfunction

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [15:0] tmr_reg;
    reg [15:0] tmr_next;
    reg tsd_reg;
    wire a_shut;
    wire b_shut;
    wire lockout = (state_reg == ST_LOCKOUT);
    // bridge-level logic only runs outside lockout and sleep
    wire logic_clear = ~(state_reg[2] | state_reg[3]);

    bridge_oc_guard #(
        .DEGLITCH_CYC(OC_DEGLITCH_CYC),
        .RETRY_CYC(OC_RETRY_CYC)
    ) u_guard_a (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .clear_in(logic_clear),
        .fet_limit_in(a_fet_limit_in),
        .sense_over_in(a_sense_over_in),
        .shut_out(a_shut)
    );
    bridge_oc_guard #(
        .DEGLITCH_CYC(OC_DEGLITCH_CYC),
        .RETRY_CYC(OC_RETRY_CYC)
    ) u_guard_b (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .clear_in(logic_clear),
        .fet_limit_in(b_fet_limit_in),
        .sense_over_in(b_sense_over_in),
        .shut_out(b_shut)
    );

    always @*
    begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        case (state_reg)
            ST_LOCKOUT:
                // rising threshold differs from falling one
                if (supply_above_rise_in)
                begin
                    tmr_next = 16'h0000;
                    if (sleep_in_low_in)
                        state_next = ST_WAKE;
                    else
                        state_next = ST_SLEEP;
                end
            ST_SLEEP:
                if (sleep_in_low_in)
                begin
                    state_next = ST_WAKE;
                    tmr_next = 16'h0000;
                end
            ST_WAKE:
                if (!sleep_in_low_in)
                    state_next = ST_SLEEP;
                else if (tmr_reg >= WAKE_CYC - 16'h0001)
                begin
                    state_next = ST_ACTIVE;
                    tmr_next = 16'h0000;
                end
                else
                    tmr_next = tmr_reg + 16'h0001;
            ST_ACTIVE:
                if (sleep_in_low_in)
                    tmr_next = 16'h0000;
                else if (tmr_reg >= SLEEP_CYC - 16'h0001)
                begin
                    state_next = ST_SLEEP;
                    tmr_next = 16'h0000;
                end
                else
                    tmr_next = tmr_reg + 16'h0001;
            default:
                state_next = ST_LOCKOUT;
        endcase
        // lockout overrides every other mode
        if (supply_below_fall_in)
        begin
            state_next = ST_LOCKOUT;
            tmr_next = 16'h0000;
        end
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_LOCKOUT;
            tmr_reg <= 16'h0000;
        end
        else if (ce_in)
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
        end
    end

    // =====================================================
    // thermal shutdown with hysteresis
    // the two comparator levels come in separately; cooled means below
    // threshold minus hysteresis, so the window is set outside this block
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tsd_reg <= 1'b0;
        else if (ce_in)
        begin
            if (logic_clear)
                tsd_reg <= 1'b0;
            else if (over_temp_in)
                tsd_reg <= 1'b1;
            else if (temp_cooled_in)
                tsd_reg <= 1'b0;
        end
    end

    // =====================================================
    // bridge drive and fault indication
    wire run = (state_reg == ST_ACTIVE);
    wire a_ok = run & ~a_shut & ~tsd_reg;
    wire b_ok = run & ~b_shut & ~tsd_reg;
    wire [3:0] a_fets = a_ok ?
        fet_map({bridge_a_input_1_in, bridge_a_input_2_in}) : 4'h0;
    wire [3:0] b_fets = b_ok ?
        fet_map({bridge_b_input_1_in, bridge_b_input_2_in}) : 4'h0;
    // or of all sources; sleep is not a fault
    wire fault_any = lockout | a_shut | b_shut | tsd_reg;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            a_high_on_out <= 2'h0;
            a_low_on_out <= 2'h0;
            b_high_on_out <= 2'h0;
            b_low_on_out <= 2'h0;
            fault_out_low_out <= 1'b0;
            fault_out_low_oe_out <= 1'b1;
            active_out <= 1'b0;
            regulator_on_out <= 1'b0;
        end
        else if (ce_in)
        begin
            a_high_on_out <= a_fets[3:2];
            a_low_on_out <= a_fets[1:0];
            b_high_on_out <= b_fets[3:2];
            b_low_on_out <= b_fets[1:0];
            // open drain: only ever drives low
            fault_out_low_out <= 1'b0;
            fault_out_low_oe_out <= fault_any;
            active_out <= run;
            regulator_on_out <= state_reg[2] | state_reg[3];
        end
    end
endmodule // hbridge_fault_mode_control

// >>> verification/hbridge_checker_properties.sv
// concurrent checks on the fault and mode controller ports
`timescale 1ns/1ns
module hbridge_checker (
    input wire clk_in, rst_n_in, ce_in, sleep_in_low_in,
    input wire bridge_a_input_1_in, bridge_a_input_2_in,
    input wire bridge_b_input_1_in, bridge_b_input_2_in,
    input wire [3:0] a_fet_limit_in, b_fet_limit_in,
    input wire a_sense_over_in, b_sense_over_in, over_temp_in,
    input wire temp_cooled_in, supply_below_fall_in, supply_above_rise_in,
    input wire [1:0] a_high_on_out, a_low_on_out, b_high_on_out,
    input wire [1:0] b_low_on_out,
    input wire fault_out_low_out, fault_out_low_oe_out, active_out,
    input wire regulator_on_out
);
    // ====
    // gate pattern {high, low} expected for an input pair
    function [3:0] dec(input [1:0] c);
        dec = {c[1] & ~c[0], ~c[1] & c[0], c[0], c[1]};
    endfunction
    default clocking cb @(posedge clk_in); endclocking
    // a frozen clock enable holds every output, so checks pause with it
    default disable iff (!rst_n_in || !ce_in);
    a_oc_shut_a: assert property ($rose(|{a_fet_limit_in, a_sense_over_in})
        ##0 (active_out && (|{a_fet_limit_in, a_sense_over_in}))[*4]
        |-> ##[0:2] ({a_high_on_out, a_low_on_out} == 4'h0
        && fault_out_low_oe_out)) else $error("bridge a not shut");
    a_decode_a: assert property ((|{a_high_on_out, a_low_on_out})
        |-> {a_high_on_out, a_low_on_out} == dec($past({bridge_a_input_1_in,
        bridge_a_input_2_in}))) else $error("bridge a decode wrong");
    a_off_idle: assert property (!regulator_on_out &&
        !$past(regulator_on_out) |-> {a_high_on_out, a_low_on_out,
        b_high_on_out, b_low_on_out} == 8'h00) else $error("fets on idle");
    a_lockout_hold: assert property (supply_below_fall_in ##1
        supply_below_fall_in |-> ##1 (fault_out_low_oe_out && !active_out
        && !regulator_on_out)) else $error("lockout not entered");
    a_thermal_off: assert property ((active_out && over_temp_in) ##1
        over_temp_in |-> ##1 (fault_out_low_oe_out && {a_high_on_out,
        a_low_on_out, b_high_on_out, b_low_on_out} == 8'h00))
        else $error("thermal not shut");
    a_sleep_entry: assert property (active_out && !sleep_in_low_in ##1
        !sleep_in_low_in |-> ##[1:3] (!active_out && !regulator_on_out))
        else $error("sleep not entered");
    a_wake_time: assert property ($rose(active_out) |->
        $past(sleep_in_low_in, 5) && sleep_in_low_in)
        else $error("active too early");
    a_retry_span: assert property ($rose(fault_out_low_oe_out) &&
        active_out && !over_temp_in && !supply_below_fall_in |->
        fault_out_low_oe_out[*8] ##[1:6] !fault_out_low_oe_out)
        else $error("retry period wrong");
endmodule // hbridge_checker
bind hbridge_fault_mode_control hbridge_checker i_chk (.*);

// >>> verification/motor_ctrl_model.sv
// controller model driving the bridge inputs and the sleep pin
`timescale 1ns/1ns
module motor_ctrl_model (
    input wire clk_in,
    input wire sleep_req_in,
    input wire [3:0] code_in,
    input wire fault_oe_in,
    output reg sleep_pin_out = 1'b0,
    output reg [3:0] pins_out = 4'h0,
    output wire fault_level_out
);
    // pins move just after the edge so the device samples a settled level
    always @(posedge clk_in)
    begin
        sleep_pin_out <= #1 ~sleep_req_in;
        pins_out <= #1 code_in;
    end
    // external pull-up: the pin reads high whenever the device lets go
    assign fault_level_out = fault_oe_in ? 1'b0 : 1'b1;
endmodule // motor_ctrl_model

// >>> verification/testbench.sv
// self-checking bench for the fault and mode controller
`timescale 1ns/1ns
module testbench;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg sleep_req = 1'b1;
    reg [3:0] code = 4'h0;
    reg [3:0] a_lim = 4'h0;
    reg a_sen = 1'b0;
    reg [3:0] b_lim = 4'h0;
    reg b_sen = 1'b0;
    reg ce = 1'b1;
    reg hot = 1'b0;
    reg cool = 1'b1;
    reg low_v = 1'b0;
    reg ok_v = 1'b1;
    wire sleep_pin, fault_level, f_data, f_oe, act, reg_on;
    wire [3:0] pins;
    wire [1:0] ah, al, bh, bl;
    integer failures = 0;
    integer n_tests = 0;
    integer i, k, c;
    // ====
    motor_ctrl_model i_ctrl (.clk_in(clk_in), .sleep_req_in(sleep_req),
        .code_in(code), .fault_oe_in(f_oe), .sleep_pin_out(sleep_pin),
        .pins_out(pins), .fault_level_out(fault_level));
    hbridge_fault_mode_control #(.OC_DEGLITCH_CYC(16'h0003),
        .OC_RETRY_CYC(16'h000A), .WAKE_CYC(16'h0005), .SLEEP_CYC(16'h0002))
    i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .sleep_in_low_in(sleep_pin), .bridge_a_input_1_in(pins[3]),
        .bridge_a_input_2_in(pins[2]), .bridge_b_input_1_in(pins[1]),
        .bridge_b_input_2_in(pins[0]), .a_fet_limit_in(a_lim),
        .b_fet_limit_in(b_lim), .a_sense_over_in(a_sen),
        .b_sense_over_in(b_sen), .over_temp_in(hot), .temp_cooled_in(cool),
        .supply_below_fall_in(low_v), .supply_above_rise_in(ok_v),
        .a_high_on_out(ah), .a_low_on_out(al), .b_high_on_out(bh),
        .b_low_on_out(bl), .fault_out_low_out(f_data),
        .fault_out_low_oe_out(f_oe), .active_out(act),
        .regulator_on_out(reg_on));
    initial forever #25 clk_in = ~clk_in;
    // coast, reverse, forward, brake as {high1, high2, low1, low2}
    function [3:0] exp4(input [1:0] p);
        exp4 = (p == 2'h0) ? 4'h0 : (p == 2'h1) ? 4'h6 : (p == 2'h2) ? 4'h9 : 4'h3;
    endfunction
    task check(input string name, input [7:0] exp, input [7:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge clk_in);
        #1;
    end
    endtask
    // bounded wait on fault enable (s=0) or active (s=1)
    task wait_sig(input integer s, input v);
    begin
        c = 0;
        while (((s == 0) ? f_oe : act) !== v && c < 400)
        begin
            tick(1);
            c = c + 1;
        end
        if (c == 400)
        begin
            $display("[FAIL] wait expected %b seen %b", v, ~v);
            failures = failures + 1;
            end_of_test;
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // ====
    initial
    begin
        tick(5);
        rst_n_in = 1'b1;
        tick(20);
        check("asleep", 8'h01, {act, reg_on, f_oe, fault_level});
        sleep_req = 1'b0;
        wait_sig(1, 1'b1);
        check("wake", 8'h01, c >= 5);
        for (i = 0; i < 16; i = i + 1)
        begin
            code = i[3:0];
            tick(3);
            check("bridges", {exp4(i[3:2]), exp4(i[1:0])}, {ah, al, bh, bl});
        end
        code = 4'hA;
        for (k = 0; k < 5; k = k + 1)
        begin
            a_lim = (k < 4) ? (4'h1 << k) : 4'h0;
            a_sen = (k == 4);
            wait_sig(0, 1'b1);
            check("oc shut", 8'h09, {ah, al, bh, bl});
            check("other bridge", 8'h09, {4'h0, bh, bl});
            check("oc deglitch", 8'h01, c >= 3);
            wait_sig(0, 1'b0);
            check("retry", 8'h01, c >= 9);
            wait_sig(0, 1'b1);
            check("repeat", 8'h01, c >= 2);
            a_lim = 4'h0;
            a_sen = 1'b0;
            wait_sig(0, 1'b0);
            tick(3);
            check("oc back", 8'h99, {ah, al, bh, bl});
        end
        b_lim = 4'h8;
        b_sen = 1'b1;
        wait_sig(0, 1'b1);
        check("b shut", 8'h90, {ah, al, bh, bl});
        b_lim = 4'h0;
        b_sen = 1'b0;
        wait_sig(0, 1'b0);
        tick(3);
        check("b back", 8'h99, {ah, al, bh, bl});
        hot = 1'b1;
        cool = 1'b0;
        wait_sig(0, 1'b1);
        tick(2);
        check("hot", 8'h00, {ah, al, bh, bl});
        hot = 1'b0;
        tick(4);
        check("hysteresis", 8'h01, {7'h00, f_oe});
        cool = 1'b1;
        wait_sig(0, 1'b0);
        tick(3);
        check("cooled", 8'h99, {ah, al, bh, bl});
        // enable low: an overtemperature seen now must not be taken
        ce = 1'b0;
        hot = 1'b1;
        tick(4);
        check("freeze", 8'h99, {ah, al, bh, bl});
        check("freeze oe", 8'h00, {7'h00, f_oe});
        hot = 1'b0;
        ce = 1'b1;
        tick(3);
        check("thawed", 8'h99, {ah, al, bh, bl});
        low_v = 1'b1;
        ok_v = 1'b0;
        tick(3);
        check("lockout", 8'h01, {act, reg_on, f_oe});
        check("lockout fets", 8'h00, {ah, al, bh, bl});
        low_v = 1'b0;
        tick(6);
        check("no rise", 8'h01, {act, reg_on, f_oe});
        ok_v = 1'b1;
        wait_sig(1, 1'b1);
        check("restart", 8'h01, {7'h00, fault_level});
        check("fault data", 8'h00, {7'h00, f_data});
        sleep_req = 1'b1;
        wait_sig(1, 1'b0);
        tick(2);
        check("sleep", 8'h00, {ah, al, bh, bl});
        check("sleep reg", 8'h00, {7'h00, reg_on});
        end_of_test;
    end
endmodule // testbench
